//--- pll_regs_pkg.sv
package pll_regs_pkg;

  // ----------------------------------------------------------------
  // Register offsets.
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FEEDBACK = 8'h03;
  localparam logic [7:0] ADDR_BYPASS = 8'h0A;
  localparam logic [7:0] ADDR_DOUBLER = 8'h0C;
  localparam logic [7:0] ADDR_LOOP = 8'h10;
  localparam logic [7:0] ADDR_OSC_OUT = 8'h11;
  localparam logic [7:0] ADDR_PUMP2 = 8'h12;
  localparam logic [7:0] ADDR_BAND = 8'h1F;

  // ----------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_FEEDBACK = 8'h00;
  localparam logic [7:0] RST_BYPASS = 8'h00;
  localparam logic [7:0] RST_DOUBLER = 8'h00;
  localparam logic [7:0] RST_LOOP = 8'h58;
  localparam logic [7:0] RST_OSC_OUT = 8'h00;
  localparam logic [7:0] RST_PUMP2 = 8'h18;
  localparam logic [7:0] RST_BAND = 8'h00;

  // ----------------------------------------------------------------
  // Implemented bits; reserved positions are masked to zero.
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_FEEDBACK = 8'h81;
  localparam logic [7:0] MASK_BYPASS = 8'h01;
  localparam logic [7:0] MASK_DOUBLER = 8'hBF;
  localparam logic [7:0] MASK_LOOP = 8'hDF;
  localparam logic [7:0] MASK_OSC_OUT = 8'hFF;
  localparam logic [7:0] MASK_PUMP2 = 8'h7F;
  localparam logic [7:0] MASK_BAND = 8'h01;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int BIT_FB_PRODUCT = 0;
  localparam int BIT_FB_MSB = 7;
  localparam int BIT_STAGE1_BYPASS = 0;
  localparam int BIT_DOUBLER = 7;
  localparam int PREDIV_LSB = 0;
  localparam int BIT_POLARITY = 6 + 1;
  localparam int BIT_FORCE_CV = 6;
  localparam int PUMP_LSB = 0;
  localparam int BIT_BUF_POWER = 7;
  localparam int BIT_BUF_FORMAT = 6;
  localparam int BIT_OFS_EN = 5;
  localparam int OFS_LSB = 0;
  localparam int AMP_LSB = 5;
  localparam int BIT_BAND = 0;

  // ----------------------------------------------------------------
  // Charge-pump current steps in microamperes.
  // ----------------------------------------------------------------
  localparam int PUMP1_STEP_UA = 50;
  localparam int PUMP2_STEP_UA = 200;

  // ----------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    SRC_PREDIV = 1'b0,
    SRC_DOUBLER = 1'b1
  } stage2_src_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    stage2_src_t second_stage_source;
    logic [5:0] second_stage_prediv;
    logic feedback_product_select;
    logic secondary_feedback_divider_msb;
    logic first_stage_enable;
    logic oscillator_polarity;
    logic force_control_voltage;
    logic [10:0] first_stage_pump_ua;
    logic [12:0] second_stage_pump_ua;
    logic osc_buffer_power;
    logic osc_buffer_format;
    logic [1:0] osc_buffer_amplitude;
    logic phase_offset_enable;
    logic [4:0] phase_offset;
    logic oscillator_band_select;
  } pll_ctrl_t;

endpackage

//--- pll_ctrl_decode.sv
`timescale 1ns/1ps
module pll_ctrl_decode (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Register contents.
  input wire logic [7:0] feedback_r,
  input wire logic [7:0] bypass_r,
  input wire logic [7:0] doubler_r,
  input wire logic [7:0] loop_r,
  input wire logic [7:0] osc_out_r,
  input wire logic [7:0] pump2_r,
  input wire logic [7:0] band_r,
  // Decoded controls.
  output pll_regs_pkg::pll_ctrl_t ctrl_r
);

  // ----------------------------------------------------------------
  // Field decode.
  // ----------------------------------------------------------------
  function automatic pll_regs_pkg::pll_ctrl_t decode(
    input logic [7:0] fb,
    input logic [7:0] byp,
    input logic [7:0] dbl,
    input logic [7:0] lp,
    input logic [7:0] osc,
    input logic [7:0] p2,
    input logic [7:0] bnd
  );
    pll_regs_pkg::pll_ctrl_t c;
    logic [10:0] code1;
    logic [12:0] code2;
    c = '0;
    code1 = {6'h00, lp[pll_regs_pkg::PUMP_LSB +: 5]} + 11'h001;
    code2 = {8'h00, p2[pll_regs_pkg::PUMP_LSB +: 5]} + 13'h0001;
    c.second_stage_source = pll_regs_pkg::stage2_src_t'(dbl[pll_regs_pkg::BIT_DOUBLER]);
    c.second_stage_prediv = dbl[pll_regs_pkg::BIT_DOUBLER] ? 6'h00 : dbl[pll_regs_pkg::PREDIV_LSB +: 6];
    c.feedback_product_select = fb[pll_regs_pkg::BIT_FB_PRODUCT];
    c.secondary_feedback_divider_msb = fb[pll_regs_pkg::BIT_FB_MSB];
    c.first_stage_enable = ~byp[pll_regs_pkg::BIT_STAGE1_BYPASS];
    c.oscillator_polarity = lp[pll_regs_pkg::BIT_POLARITY];
    c.force_control_voltage = lp[pll_regs_pkg::BIT_FORCE_CV];
    c.first_stage_pump_ua = 11'(code1 * 11'(pll_regs_pkg::PUMP1_STEP_UA));
    c.second_stage_pump_ua = 13'(code2 * 13'(pll_regs_pkg::PUMP2_STEP_UA));
    c.osc_buffer_power = osc[pll_regs_pkg::BIT_BUF_POWER];
    c.osc_buffer_format = osc[pll_regs_pkg::BIT_BUF_FORMAT];
    c.phase_offset_enable = osc[pll_regs_pkg::BIT_OFS_EN];
    c.phase_offset = osc[pll_regs_pkg::OFS_LSB +: 5];
    c.osc_buffer_amplitude = p2[pll_regs_pkg::AMP_LSB +: 2];
    c.oscillator_band_select = bnd[pll_regs_pkg::BIT_BAND];
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Registered controls.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r <= decode(pll_regs_pkg::RST_FEEDBACK, pll_regs_pkg::RST_BYPASS, pll_regs_pkg::RST_DOUBLER,
                       pll_regs_pkg::RST_LOOP, pll_regs_pkg::RST_OSC_OUT, pll_regs_pkg::RST_PUMP2,
                       pll_regs_pkg::RST_BAND);
    end else if (ce) begin
      ctrl_r <= decode(feedback_r, bypass_r, doubler_r, loop_r, osc_out_r, pump2_r, band_r);
    end
  end

endmodule

//--- dual_pll_control_registers.sv
`timescale 1ns/1ps
module dual_pll_control_registers (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Register access.
  input wire pll_regs_pkg::reg_req_t req,
  output logic [7:0] rdata_r,
  output logic rvalid_r,
  // Decoded PLL controls.
  output pll_regs_pkg::pll_ctrl_t ctrl_r
);

  logic [7:0] feedback_r;
  logic [7:0] bypass_r;
  logic [7:0] doubler_r;
  logic [7:0] loop_r;
  logic [7:0] osc_out_r;
  logic [7:0] pump2_r;
  logic [7:0] band_r;
  logic [7:0] rdata_nxt;

  // ----------------------------------------------------------------
  // Configuration registers.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      feedback_r <= pll_regs_pkg::RST_FEEDBACK;
    end else if (ce && req.wr && req.addr == pll_regs_pkg::ADDR_FEEDBACK) begin
      feedback_r <= req.wdata & pll_regs_pkg::MASK_FEEDBACK;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bypass_r <= pll_regs_pkg::RST_BYPASS;
    end else if (ce && req.wr && req.addr == pll_regs_pkg::ADDR_BYPASS) begin
      bypass_r <= req.wdata & pll_regs_pkg::MASK_BYPASS;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      doubler_r <= pll_regs_pkg::RST_DOUBLER;
    end else if (ce && req.wr && req.addr == pll_regs_pkg::ADDR_DOUBLER) begin
      doubler_r <= req.wdata & pll_regs_pkg::MASK_DOUBLER;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      loop_r <= pll_regs_pkg::RST_LOOP;
    end else if (ce && req.wr && req.addr == pll_regs_pkg::ADDR_LOOP) begin
      loop_r <= req.wdata & pll_regs_pkg::MASK_LOOP;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      osc_out_r <= pll_regs_pkg::RST_OSC_OUT;
    end else if (ce && req.wr && req.addr == pll_regs_pkg::ADDR_OSC_OUT) begin
      osc_out_r <= req.wdata & pll_regs_pkg::MASK_OSC_OUT;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pump2_r <= pll_regs_pkg::RST_PUMP2;
    end else if (ce && req.wr && req.addr == pll_regs_pkg::ADDR_PUMP2) begin
      pump2_r <= req.wdata & pll_regs_pkg::MASK_PUMP2;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      band_r <= pll_regs_pkg::RST_BAND;
    end else if (ce && req.wr && req.addr == pll_regs_pkg::ADDR_BAND) begin
      band_r <= req.wdata & pll_regs_pkg::MASK_BAND;
    end
  end

  // ----------------------------------------------------------------
  // Read-back path.
  // ----------------------------------------------------------------
  always_comb begin
    if (req.addr == pll_regs_pkg::ADDR_FEEDBACK) begin
      rdata_nxt = feedback_r;
    end else if (req.addr == pll_regs_pkg::ADDR_BYPASS) begin
      rdata_nxt = bypass_r;
    end else if (req.addr == pll_regs_pkg::ADDR_DOUBLER) begin
      rdata_nxt = doubler_r;
    end else if (req.addr == pll_regs_pkg::ADDR_LOOP) begin
      rdata_nxt = loop_r;
    end else if (req.addr == pll_regs_pkg::ADDR_OSC_OUT) begin
      rdata_nxt = osc_out_r;
    end else if (req.addr == pll_regs_pkg::ADDR_PUMP2) begin
      rdata_nxt = pump2_r;
    end else if (req.addr == pll_regs_pkg::ADDR_BAND) begin
      rdata_nxt = band_r;
    end else begin
      rdata_nxt = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else if (ce) begin
      rvalid_r <= req.rd;
      if (req.rd) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control decode.
  // ----------------------------------------------------------------
  pll_ctrl_decode u_decode (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .feedback_r(feedback_r),
    .bypass_r(bypass_r),
    .doubler_r(doubler_r),
    .loop_r(loop_r),
    .osc_out_r(osc_out_r),
    .pump2_r(pump2_r),
    .band_r(band_r),
    .ctrl_r(ctrl_r)
  );

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking

  default disable iff (srst);

  chk_doubler_source: assert property (
    ce |=> ctrl_r.second_stage_source == pll_regs_pkg::stage2_src_t'($past(doubler_r[7])))
    else $error("Second-stage source does not follow the doubler bit.");

  chk_prediv_ignored: assert property (
    ce && doubler_r[7] |=> ctrl_r.second_stage_prediv == 6'h00)
    else $error("Pre-divider not ignored while doubling.");

  chk_band_reset: assert property (
    @(posedge clk) disable iff (1'b0) srst |=> band_r == 8'h00 && ctrl_r.oscillator_band_select == 1'b0)
    else $error("Band select not zero after reset.");

  chk_feedback_mode: assert property (
    ce && req.wr && req.addr == pll_regs_pkg::ADDR_FEEDBACK ##1 ce
    |=> ctrl_r.feedback_product_select == $past(req.wdata[0], 2))
    else $error("Feedback product select does not follow the write.");

  chk_stage1_enable: assert property (
    ce |=> ctrl_r.first_stage_enable == !$past(bypass_r[0]))
    else $error("First-stage enable not the inverse of bypass.");

  chk_polarity: assert property (
    ce |=> ctrl_r.oscillator_polarity == $past(loop_r[7]))
    else $error("Oscillator polarity does not follow its bit.");

  chk_force_cv: assert property (
    ce |=> ctrl_r.force_control_voltage == $past(loop_r[6]))
    else $error("Force control voltage does not follow its bit.");

  chk_force_reset: assert property (
    @(posedge clk) disable iff (1'b0) srst ##1 !srst
    |-> loop_r[6] && ctrl_r.force_control_voltage && ctrl_r.first_stage_pump_ua == 11'h4e2)
    else $error("Startup centering or pump default missing after reset.");

  chk_pump_current: assert property (
    ce |=> ctrl_r.first_stage_pump_ua == 11'(({6'h00, $past(loop_r[4:0])} + 11'h001) * 11'h032))
    else $error("First-stage pump current wrong for its code.");

  chk_buffer_power: assert property (
    ce |=> ctrl_r.osc_buffer_power == $past(osc_out_r[7]))
    else $error("Buffer power does not follow its bit.");

  chk_reserved_zero: assert property (
    (loop_r & ~pll_regs_pkg::MASK_LOOP) == 8'h00 && (pump2_r & ~pll_regs_pkg::MASK_PUMP2) == 8'h00
    && (feedback_r & ~pll_regs_pkg::MASK_FEEDBACK) == 8'h00)
    else $error("Reserved register bit is set.");

  chk_readback: assert property (
    ce && req.wr && !req.rd && req.addr == pll_regs_pkg::ADDR_OSC_OUT ##1 ce && req.rd
    && req.addr == pll_regs_pkg::ADDR_OSC_OUT |=> rvalid_r && rdata_r == $past(req.wdata, 2))
    else $error("Read-back differs from written value.");

  cov_force_cleared: cover property (
    ce && req.wr && req.addr == pll_regs_pkg::ADDR_LOOP && !req.wdata[6] ##2 !ctrl_r.force_control_voltage);

  cov_doubler_on: cover property (
    ctrl_r.second_stage_source == pll_regs_pkg::SRC_DOUBLER);

  cov_stage1_bypassed: cover property (
    !ctrl_r.first_stage_enable);

  cov_buffer_up: cover property (
    ctrl_r.osc_buffer_power && rvalid_r);

endmodule

//--- dual_pll_control_registers_bench.sv
`timescale 1ns/1ps
module dual_pll_control_registers_bench;
  // ----------------------------------------------------------------
  // Signals and design instance.
  // ----------------------------------------------------------------
  logic clk;
  logic srst;
  logic ce;
  pll_regs_pkg::reg_req_t req;
  logic [7:0] rdata_r;
  logic rvalid_r;
  pll_regs_pkg::pll_ctrl_t ctrl_r;
  int num_errors;
  int check_count;
  logic [7:0] reg_addr [7] = '{8'h03, 8'h0a, 8'h0c, 8'h10, 8'h11, 8'h12, 8'h1f};
  logic [7:0] reg_rst [7] = '{8'h00, 8'h00, 8'h00, 8'h58, 8'h00, 8'h18, 8'h00};
  logic [7:0] reg_mask [7] = '{8'h81, 8'h01, 8'hbf, 8'hdf, 8'hff, 8'h7f, 8'h01};

  dual_pll_control_registers u_dut (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .req(req),
    .rdata_r(rdata_r),
    .rvalid_r(rvalid_r),
    .ctrl_r(ctrl_r)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    while (rvalid_r !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (rvalid_r !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, rvalid_r, 1'b1);
      tally_and_finish();
    end else begin
      d = rdata_r;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic test_defaults();
    logic [7:0] d;
    for (int i = 0; i < 7; i++) begin
      rd(reg_addr[i], d);
      check(16'(d), 16'(reg_rst[i]));
    end
    check(16'(ctrl_r.force_control_voltage), 16'h0001);
    check(16'(ctrl_r.first_stage_enable), 16'h0001);
    check(16'(ctrl_r.feedback_product_select), 16'h0000);
    check(16'(ctrl_r.oscillator_polarity), 16'h0000);
    check(16'(ctrl_r.first_stage_pump_ua), 16'h04e2);
    check(16'(ctrl_r.osc_buffer_power), 16'h0000);
    check(16'(ctrl_r.oscillator_band_select), 16'h0000);
    check(16'(ctrl_r.second_stage_source), 16'h0000);
    check(16'(ctrl_r.second_stage_pump_ua), 16'h1388);
  endtask

  task automatic test_readback();
    logic [7:0] d;
    logic [7:0] v;
    for (int i = 0; i < 7; i++) begin
      v = (reg_addr[i] == 8'h1f) ? 8'hfe : 8'hff;
      wr(reg_addr[i], v);
      rd(reg_addr[i], d);
      check(16'(d), 16'(v & reg_mask[i]));
    end
    check(16'(ctrl_r.feedback_product_select), 16'h0001);
    check(16'(ctrl_r.first_stage_enable), 16'h0000);
    check(16'(ctrl_r.oscillator_polarity), 16'h0001);
    check(16'(ctrl_r.force_control_voltage), 16'h0001);
    check(16'(ctrl_r.first_stage_pump_ua), 16'h0640);
    check(16'(ctrl_r.osc_buffer_power), 16'h0001);
    check(16'(ctrl_r.oscillator_band_select), 16'h0000);
    check(16'(ctrl_r.second_stage_source), 16'h0001);
    check(16'(ctrl_r.second_stage_prediv), 16'h0000);
    check(16'(ctrl_r.secondary_feedback_divider_msb), 16'h0001);
    check(16'(ctrl_r.osc_buffer_format), 16'h0001);
    check(16'(ctrl_r.phase_offset_enable), 16'h0001);
    check(16'(ctrl_r.phase_offset), 16'h001f);
    check(16'(ctrl_r.osc_buffer_amplitude), 16'h0003);
    check(16'(ctrl_r.second_stage_pump_ua), 16'h1900);
    wr(8'h20, 8'hff);
    rd(8'h20, d);
    check(16'(d), 16'h0000);
  endtask

  task automatic test_doubler();
    wr(8'h0c, 8'h05);
    @(negedge clk);
    check(16'(ctrl_r.second_stage_source), 16'h0000);
    check(16'(ctrl_r.second_stage_prediv), 16'h0005);
    wr(8'h0c, 8'h85);
    @(negedge clk);
    check(16'(ctrl_r.second_stage_source), 16'h0001);
    check(16'(ctrl_r.second_stage_prediv), 16'h0000);
  endtask

  task automatic test_loop_fields();
    wr(8'h10, 8'h40);
    @(negedge clk);
    check(16'(ctrl_r.force_control_voltage), 16'h0001);
    check(16'(ctrl_r.oscillator_polarity), 16'h0000);
    check(16'(ctrl_r.first_stage_pump_ua), 16'h0032);
    wr(8'h03, 8'h00);
    wr(8'h0a, 8'h00);
    wr(8'h11, 8'h00);
    @(negedge clk);
    check(16'(ctrl_r.feedback_product_select), 16'h0000);
    check(16'(ctrl_r.first_stage_enable), 16'h0001);
    check(16'(ctrl_r.osc_buffer_power), 16'h0000);
    wr(8'h10, 8'h18);
    @(negedge clk);
    check(16'(ctrl_r.force_control_voltage), 16'h0000);
    check(16'(ctrl_r.first_stage_pump_ua), 16'h04e2);
  endtask

  task automatic test_back_to_back();
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = 8'h11;
    req.wdata = 8'h5a;
    @(negedge clk);
    req.rd = 1'b1;
    req.wdata = 8'ha5;
    @(negedge clk);
    req.wr = 1'b0;
    check(16'(rvalid_r), 16'h0001);
    check(16'(rdata_r), 16'h005a);
    @(negedge clk);
    req.rd = 1'b0;
    check(16'(rvalid_r), 16'h0001);
    check(16'(rdata_r), 16'h00a5);
  endtask

  task automatic test_ce_hold();
    logic [7:0] d;
    ce = 1'b0;
    wr(8'h0a, 8'h01);
    ce = 1'b1;
    rd(8'h0a, d);
    check(16'(d), 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    req = '0;
    num_errors = 0;
    check_count = 0;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    test_defaults();
    test_readback();
    test_doubler();
    test_loop_fields();
    test_back_to_back();
    test_ce_hold();
    wr(8'h10, 8'h00);
    @(negedge clk);
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    test_defaults();
    tally_and_finish();
  end
endmodule
